// file: hdl/full_status_responder.sv
// Full-status request handler of a LIN slave LED driver, with AXI4-Lite registers.
// Assumes a protocol handler on mclk: header, byte and done pulses, bit compare strobe.
`timescale 1ns/1ps
`default_nettype none
module full_status_responder
  import full_status_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Protocol handler side
  input  wire logic        hdrValid,
  input  wire logic [5:0]  hdrId,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxData,
  output logic             txValid,
  output logic [7:0]       txData,
  input  wire logic        txReady,
  input  wire logic        txDone,
  input  wire logic        dataErrPulse,
  input  wire logic        headerErrPulse,
  input  wire logic        bitCheck,
  input  wire logic        bitSent,
  input  wire logic        bitMonitored,
  // Device state
  input  wire logic [5:0]  nodeAddress,
  input  wire logic [3:0]  groupSelectField,
  input  wire logic [2:0]  ledEnable,
  input  wire logic        ledsOn,
  input  wire logic        supplyUndervoltage,
  input  wire logic        supplyResetEvent,
  input  wire logic        thermalWarning,
  input  wire logic        thermalShutdown,
  input  wire logic [1:0]  temperatureState,
  input  wire logic        thermalDerateEnable,
  input  wire logic [3:0]  thermalDerateLevel,
  input  wire logic        faultRetryEvent,
  input  wire logic [8:0]  ledFaultLive,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] csumAdd(input logic [7:0] acc, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, acc} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction

  function automatic logic [7:0] reqExpected(input logic [3:0] idx, input logic [5:0] addr);
    if (idx == 4'h0) begin
      return APP_CMD_BYTE;
    end else if (idx == 4'h1) begin
      return {1'b1, FULL_STATUS_CMD};
    end else if (idx == 4'h2) begin
      return {TOP_BITS_SET, addr};
    end else begin
      return FILL_BYTE;
    end
  endfunction

  resp_state_t state_q;
  logic [3:0]  idx_q;
  logic [7:0]  sum_q;
  logic        match_q;
  logic        respEn_q;
  logic        clearFlags;
  logic        twL_q, tsdL_q, supResetL_q, retryL_q;
  logic [8:0]  ledCode_q;
  logic [2:0]  linErr_q;
  logic [7:0]  respByte;
  logic        reqEnd, reqGood, csumBad, bitErr;

  // ----------------------------------------------------------------
  // Request parse and response sequencing
  // ----------------------------------------------------------------
  assign reqEnd     = (state_q == ST_COLLECT) && rxValid && (idx_q == CHECKSUM_IDX);
  assign csumBad    = reqEnd && (rxData != ~sum_q);
  assign reqGood    = reqEnd && !csumBad && match_q && respEn_q;
  assign clearFlags = (state_q == ST_WAIT_DONE) && txDone;
  assign bitErr     = bitCheck && (bitSent != bitMonitored);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      idx_q   <= 4'h0;
      sum_q   <= 8'h00;
      match_q <= 1'b0;
    end else if (hdrValid && hdrId == REQ_FRAME_ID) begin
      // A new request always supersedes whatever was under way
      state_q <= ST_COLLECT;
      idx_q   <= 4'h0;
      sum_q   <= 8'h00;
      match_q <= 1'b1;
    end else begin
      case (state_q)
        ST_COLLECT: begin
          if (rxValid) begin
            idx_q   <= idx_q + 4'h1;
            sum_q   <= csumAdd(sum_q, rxData);
            match_q <= match_q && (idx_q == CHECKSUM_IDX || rxData == reqExpected(idx_q, nodeAddress));
            if (idx_q == CHECKSUM_IDX) begin
              state_q <= reqGood ? ST_PENDING : ST_IDLE;
            end
          end
        end
        ST_PENDING: begin
          if (hdrValid) begin
            state_q <= (hdrId == RESP_FRAME_ID) ? ST_SEND : ST_IDLE;
            idx_q   <= 4'h0;
            sum_q   <= 8'h00;
          end
        end
        ST_SEND: begin
          if (txReady && txValid) begin
            idx_q <= idx_q + 4'h1;
            sum_q <= csumAdd(sum_q, txData);
            if (idx_q == CHECKSUM_IDX) begin
              state_q <= ST_WAIT_DONE;
            end
          end
        end
        ST_WAIT_DONE: begin
          if (txDone) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Response bytes
  // ----------------------------------------------------------------
  always_comb begin
    case (idx_q)
      4'h0: respByte = {TOP_BITS_SET, nodeAddress};
      4'h1: respByte = FILL_BYTE;
      4'h2: respByte = {5'h1F, linErr_q};
      4'h3: respByte = {TOP_BITS_SET, supplyUndervoltage, supResetL_q, tsdL_q, twL_q, temperatureState};
      4'h4: respByte = {thermalDerateEnable ? thermalDerateLevel : DERATE_FULL, retryL_q, ledCode_q[2:0]};
      4'h5: respByte = {1'b1, ledCode_q[8:6], 1'b1, ledCode_q[5:3]};
      4'h6: respByte = {ledEnable, ledsOn, groupSelectField};
      4'h7: respByte = FILL_BYTE;
      default: respByte = ~sum_q;
    endcase
  end

  // Data is registered on the same edge that raises txValid
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      txValid <= 1'b0;
      txData  <= 8'h00;
    end else if (state_q == ST_SEND && !(txValid && txReady)) begin
      txValid <= 1'b1;
      txData  <= respByte;
    end else begin
      txValid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Latched flags: live condition wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      twL_q       <= 1'b0;
      tsdL_q      <= 1'b0;
      supResetL_q <= 1'b0;
      retryL_q    <= 1'b0;
    end else begin
      twL_q       <= thermalWarning | (twL_q & ~clearFlags);
      tsdL_q      <= thermalShutdown | (tsdL_q & ~clearFlags);
      supResetL_q <= supplyResetEvent | (supResetL_q & ~clearFlags);
      retryL_q    <= faultRetryEvent | (retryL_q & ~clearFlags);
    end
  end

  // Codes pass as detected (000, 011, 101, 010); a fault holds until a clear or another nonzero code replaces it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ledCode_q <= {3{LED_NO_FAULT}};
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (clearFlags || ledFaultLive[i*3 +: 3] != LED_NO_FAULT) begin
          ledCode_q[i*3 +: 3] <= ledFaultLive[i*3 +: 3];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      linErr_q <= 3'h0;
    end else begin
      linErr_q[2] <= dataErrPulse | csumBad | (linErr_q[2] & ~clearFlags);
      linErr_q[1] <= headerErrPulse | (linErr_q[1] & ~clearFlags);
      linErr_q[0] <= bitErr | (linErr_q[0] & ~clearFlags);
    end
  end

  // ----------------------------------------------------------------
  // Registers and interrupt
  // ----------------------------------------------------------------
  logic [EVENT_COUNT-1:0] irqStatus_q, irqMask_q, events;
  logic                   awHave_q, wHave_q;
  logic [7:0]             awAddr_q;
  logic [31:0]            wData_q;
  logic [3:0]             wStrb_q;
  logic                   doWrite;

  assign events        = {bitErr, csumBad, clearFlags, reqGood};
  assign s_axi_awready = !awHave_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHave_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite       = awHave_q && wHave_q && !s_axi_bvalid;
  assign irq           = |(irqStatus_q & irqMask_q);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_q     <= 1'b0;
      wHave_q      <= 1'b0;
      awAddr_q     <= 8'h00;
      wData_q      <= 32'h00000000;
      wStrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_q == IRQ_STATUS_ADDR || awAddr_q == IRQ_MASK_ADDR ||
                         awAddr_q == CTRL_ADDR || awAddr_q == FLAGS_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write-one-to-clear; a new event in the same cycle stays set
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_q <= '0;
      irqMask_q   <= IRQ_MASK_RESET;
      respEn_q    <= RESP_EN_RESET;
    end else begin
      if (doWrite && wStrb_q[0] && awAddr_q == IRQ_STATUS_ADDR) begin
        irqStatus_q <= (irqStatus_q & ~wData_q[EVENT_COUNT-1:0]) | events;
      end else begin
        irqStatus_q <= irqStatus_q | events;
      end
      if (doWrite && wStrb_q[0] && awAddr_q == IRQ_MASK_ADDR) begin
        irqMask_q <= wData_q[EVENT_COUNT-1:0];
      end
      if (doWrite && wStrb_q[0] && awAddr_q == CTRL_ADDR) begin
        respEn_q <= wData_q[0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == IRQ_STATUS_ADDR) begin
        s_axi_rdata <= {28'h0000000, irqStatus_q};
      end else if (s_axi_araddr == IRQ_MASK_ADDR) begin
        s_axi_rdata <= {28'h0000000, irqMask_q};
      end else if (s_axi_araddr == CTRL_ADDR) begin
        s_axi_rdata <= {28'h0000000, state_q == ST_PENDING, 2'h0, respEn_q};
      end else if (s_axi_araddr == FLAGS_ADDR) begin
        s_axi_rdata <= {16'h0000, ledCode_q, linErr_q, retryL_q, supResetL_q, tsdL_q, twL_q};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence respHeaderSeen;
    state_q == ST_PENDING && hdrValid && hdrId == RESP_FRAME_ID;
  endsequence
  sequence firstByteOffered;
    txValid && idx_q == 4'h0;
  endsequence

  chk_resp_starts_addr: assert property (respHeaderSeen |-> ##2 firstByteOffered ##0 txData == {TOP_BITS_SET, nodeAddress})
    else $error("Response did not open with address byte");
  chk_fill_bytes: assert property (txValid && (idx_q == 4'h1 || idx_q == 4'h7) |-> txData == FILL_BYTE)
    else $error("Fill byte wrong");
  chk_err_byte_ones: assert property (txValid && idx_q == 4'h2 |-> txData[7:3] == 5'h1F)
    else $error("Error byte top bits not set");
  chk_supply_byte: assert property (txValid && idx_q == 4'h3 |-> txData[7:6] == TOP_BITS_SET)
    else $error("Supply byte top bits not set");
  chk_led_byte_ones: assert property (txValid && idx_q == 4'h5 |-> txData[7] && txData[3])
    else $error("LED byte fixed bits not set");
  chk_tw_latches: assert property (thermalWarning && !clearFlags |=> twL_q ##1 (twL_q || $past(clearFlags)))
    else $error("Thermal warning not latched");
  chk_flag_reclear: assert property (clearFlags && !thermalShutdown |=> !tsdL_q)
    else $error("Shutdown flag not cleared");
  chk_flag_persist: assert property (clearFlags && thermalWarning |=> twL_q)
    else $error("Persistent warning lost on clear");
  chk_no_early_clear: assert property (state_q == ST_SEND && twL_q |=> twL_q)
    else $error("Flag cleared during response");
  chk_csum_reject: assert property (csumBad |=> state_q == ST_IDLE && linErr_q[2])
    else $error("Bad checksum not rejected");
  chk_addr_silent: assert property (reqEnd && !match_q |=> state_q != ST_PENDING)
    else $error("Answered foreign address");
  chk_bit_error: assert property (bitErr |=> linErr_q[0])
    else $error("Bit error not flagged");
  chk_lin_err_reset: assert property (clearFlags && !dataErrPulse && !headerErrPulse && !bitErr |=> linErr_q == 3'h0)
    else $error("LIN error flags not reset");
  chk_request_good: assert property (reqGood |-> ##1 state_q == ST_PENDING)
    else $error("Valid request not held pending");

endmodule
`default_nettype wire

// file: inc/full_status_pkg.sv
// Constants shared by the full-status responder: frame identifiers,
// request and response byte layout, and the register map of the AXI4-Lite slave.
// Assumes a LIN protocol handler on the same clock that delivers checked bytes.
package full_status_pkg;

  // ----------------------------------------------------------------
  // Frame identifiers and request layout
  // ----------------------------------------------------------------
  localparam logic [5:0] REQ_FRAME_ID   = 6'h3C;
  localparam logic [5:0] RESP_FRAME_ID  = 6'h3D;
  localparam logic [7:0] APP_CMD_BYTE   = 8'h80;
  localparam logic [6:0] FULL_STATUS_CMD = 7'h01;
  localparam logic [7:0] FILL_BYTE      = 8'hFF;
  localparam logic [1:0] TOP_BITS_SET   = 2'h3;
  localparam logic [3:0] LAST_DATA_IDX  = 4'h7;
  localparam logic [3:0] CHECKSUM_IDX   = 4'h8;

  // ----------------------------------------------------------------
  // LED fault codes and thermal derate
  // ----------------------------------------------------------------
  localparam logic [2:0] LED_NO_FAULT     = 3'h0;
  localparam logic [2:0] LED_OPEN_SENSE   = 3'h3;
  localparam logic [2:0] LED_OPEN_ANODE   = 3'h5;
  localparam logic [2:0] LED_SHORT_GROUND = 3'h2;
  localparam logic [3:0] DERATE_FULL      = 4'hF;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h00;
  localparam logic [7:0] IRQ_MASK_ADDR   = 8'h04;
  localparam logic [7:0] CTRL_ADDR       = 8'h08;
  localparam logic [7:0] FLAGS_ADDR      = 8'h0C;
  localparam int         EVENT_COUNT     = 4;
  localparam int         EV_REQ_TAKEN    = 0;
  localparam int         EV_RESP_SENT    = 1;
  localparam int         EV_CSUM_REJECT  = 2;
  localparam int         EV_BIT_ERROR    = 3;
  localparam logic [3:0] IRQ_MASK_RESET  = 4'h0;
  localparam logic       RESP_EN_RESET   = 1'b1;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_COLLECT, ST_PENDING, ST_SEND, ST_WAIT_DONE} resp_state_t;

endpackage

// file: verification/lin_master_model.sv
// LIN master with protocol handler front end, facing the full-status responder.
// Assumes its tasks are called just after a rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module lin_master_model (
  input  wire logic       mclk,
  output logic            hdrValid,
  output logic [5:0]      hdrId,
  output logic            rxValid,
  output logic [7:0]      rxData,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  output logic            txDone
);
  logic [7:0] got [0:8];
  int         nGot;

  initial begin
    {hdrValid, rxValid, txReady, txDone} = 4'h0;
    hdrId  = 6'h00;
    rxData = 8'h00;
  end

  // Classic sum with end-around carry, inverted
  function automatic logic [7:0] csum(input logic [7:0] b [0:8]);
    logic [8:0] s;
    s = 9'h000;
    for (int i = 0; i < 8; i++) s = s[7:0] + s[8] + b[i];
    s = s[7:0] + s[8];
    s = s[7:0] + s[8];
    return ~s[7:0];
  endfunction

  task automatic header(input logic [5:0] id);
    @(posedge mclk);
    hdrValid <= 1'b1;
    hdrId    <= id;
    @(posedge mclk);
    hdrValid <= 1'b0;
    hdrId    <= ~id;
  endtask

  // Released lines show the inverse so a stale byte is never mistaken for a fresh one
  task automatic request(input logic [5:0] addr, input logic badSum);
    logic [7:0] b [0:8];
    b = '{8'h80, 8'h81, {2'h3, addr}, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    b[8] = csum(b) ^ {7'h00, badSum};
    header(6'h3C);
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk);
      rxValid <= 1'b1;
      rxData  <= b[i];
      @(posedge mclk);
      rxValid <= 1'b0;
      rxData  <= ~b[i];
    end
  endtask

  // Random stalls on txReady make the answer both prompt and slow
  task automatic collect(input int limit);
    logic hit;
    nGot = 0;
    for (int t = 0; t < limit && nGot < 9; t++) begin
      @(negedge mclk);
      hit = txValid && txReady;
      if (hit) got[nGot] = txData;
      @(posedge mclk);
      if (hit) nGot++;
      txReady <= ($urandom % 3) != 0;
    end
    @(posedge mclk);
    txReady <= 1'b0;
    txDone  <= nGot == 9;
    @(posedge mclk);
    txDone  <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: verification/test_full_status_responder.sv
// Self-checking bench for the full-status responder.
// Assumes the LIN side model in lin_master_model and an AXI4-Lite master here.
`timescale 1ns/1ps
`default_nettype none
module test_full_status_responder;
  import full_status_pkg::*;
  logic        mclk, rst_n, hdrValid, rxValid, txValid, txReady, txDone, irq;
  logic        dataErrPulse, headerErrPulse, bitCheck, bitSent, bitMonitored, ledsOn;
  logic        supplyUndervoltage, supplyResetEvent, thermalWarning, thermalShutdown;
  logic        thermalDerateEnable, faultRetryEvent, pSr, pTw, pTsd, pRt, bitE;
  logic [5:0]  hdrId, nodeAddress;
  logic [7:0]  rxData, txData, s_axi_awaddr, s_axi_araddr;
  logic [3:0]  groupSelectField, thermalDerateLevel, s_axi_wstrb;
  logic [2:0]  ledEnable, linE;
  logic [1:0]  temperatureState, s_axi_bresp, s_axi_rresp, r;
  logic [8:0]  ledFaultLive, pLed;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          errCount, nChecks;

  full_status_responder dut (.*);
  lin_master_model lin (.mclk(mclk), .hdrValid(hdrValid), .hdrId(hdrId), .rxValid(rxValid), .rxData(rxData),
    .txValid(txValid), .txData(txData), .txReady(txReady), .txDone(txDone));

  always #10 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic pa, pw, pb, hA, hW, hB;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    {pa, pw, pb} = 3'h7;
    for (int t = 0; t < 100 && pb; t++) begin
      @(negedge mclk);
      {hA, hW, hB} = {pa && s_axi_awready, pw && s_axi_wready, s_axi_bvalid === 1'b1};
      rs = s_axi_bresp;
      @(posedge mclk);
      if (hA) s_axi_awvalid <= 1'b0;
      if (hW) s_axi_wvalid <= 1'b0;
      if (hB) s_axi_bready <= 1'b0;
      {pa, pw, pb} = {pa && !hA, pw && !hW, !hB};
    end
    if (pb) errCount++;
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic pa, pr, hA, hR;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    {pa, pr} = 2'h3;
    for (int t = 0; t < 100 && pr; t++) begin
      @(negedge mclk);
      {hA, hR} = {pa && s_axi_arready, s_axi_rvalid === 1'b1};
      {rs, v} = {s_axi_rresp, s_axi_rdata};
      @(posedge mclk);
      if (hA) s_axi_arvalid <= 1'b0;
      if (hR) s_axi_rready <= 1'b0;
      {pa, pr} = {pa && !hA, !hR};
    end
    if (pr) errCount++;
  endtask

  // ----------------------------------------------------------------
  // Stimulus and expectations
  // ----------------------------------------------------------------
  function automatic logic [2:0] ledCode();
    logic [2:0] tbl [0:3];
    tbl = '{LED_NO_FAULT, LED_OPEN_SENSE, LED_OPEN_ANODE, LED_SHORT_GROUND};
    return tbl[$urandom % 4];
  endfunction

  // A nonzero live code overrides; otherwise the code captured at the last clear stays
  function automatic logic [7:0] expByte(input int i);
    logic [2:0] c [0:2];
    for (int k = 0; k < 3; k++) c[k] = (ledFaultLive[3*k+:3] != 3'h0) ? ledFaultLive[3*k+:3] : pLed[3*k+:3];
    case (i)
      0: return {2'h3, nodeAddress};
      2: return {5'h1F, linE};
      3: return {2'h3, supplyUndervoltage, supplyResetEvent | pSr, thermalShutdown | pTsd,
                 thermalWarning | pTw, temperatureState};
      4: return {thermalDerateEnable ? thermalDerateLevel : 4'hF, faultRetryEvent | pRt, c[0]};
      5: return {1'b1, c[2], 1'b1, c[1]};
      6: return {ledEnable, ledsOn, groupSelectField};
      default: return 8'hFF;
    endcase
  endfunction

  task automatic randomState(input int it);
    @(posedge mclk);
    nodeAddress      <= 6'($urandom);
    groupSelectField <= 4'($urandom);
    {ledEnable, ledsOn, temperatureState} <= 6'($urandom);
    {supplyUndervoltage, supplyResetEvent, thermalWarning, thermalShutdown, faultRetryEvent} <= 5'($urandom);
    thermalDerateEnable <= (it < 3) || 1'($urandom);
    thermalDerateLevel  <= (it == 0) ? 4'h0 : (it == 1) ? 4'hE : (it == 2) ? 4'hF : 4'($urandom);
    ledFaultLive <= {ledCode(), ledCode(), ledCode()};
  endtask

  // Bit compare strobe with a mismatch only when the drawn bit is set
  task automatic pulses();
    logic [2:0] p;
    p = 3'($urandom);
    @(posedge mclk);
    {dataErrPulse, headerErrPulse, bitCheck, bitSent, bitMonitored} <= {p[2:1], 2'h3, ~p[0]};
    @(posedge mclk);
    {dataErrPulse, headerErrPulse, bitCheck} <= 3'h0;
    linE = linE | p;
    bitE = bitE | p[0];
  endtask

  initial begin
    #200us;
    errCount++;
    stopTest();
  end

  initial begin
    void'($urandom(3626));
    {mclk, rst_n, dataErrPulse, headerErrPulse, bitCheck, bitSent, bitMonitored, ledsOn} = 8'h00;
    {supplyUndervoltage, supplyResetEvent, thermalWarning, thermalShutdown, thermalDerateEnable} = 5'h00;
    {faultRetryEvent, pSr, pTw, pTsd, pRt, bitE, linE, pLed} = 18'h00000;
    {nodeAddress, groupSelectField, thermalDerateLevel, ledEnable, temperatureState, ledFaultLive} = 28'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {errCount, nChecks} = 64'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    axiRead(IRQ_STATUS_ADDR, d, r);
    check(d, 32'h0);
    axiRead(IRQ_MASK_ADDR, d, r);
    check(d, 32'h0);
    axiRead(CTRL_ADDR, d, r);
    check(d, 32'h1);
    axiRead(8'h10, d, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check(d, 32'h0);
    axiWrite(8'h10, 32'hF, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test registers done");
    axiWrite(IRQ_MASK_ADDR, 32'h4, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
    lin.request(nodeAddress, 1'b1);
    axiRead(IRQ_STATUS_ADDR, d, r);
    check(d, 32'h4);
    check({31'h0, irq}, 32'h1);
    lin.header(RESP_FRAME_ID);
    lin.collect(40);
    check(lin.nGot, 0);
    axiWrite(IRQ_STATUS_ADDR, 32'h4, r);
    check({31'h0, irq}, 32'h0);
    linE = 3'h4;
    lin.request(nodeAddress ^ 6'h01, 1'b0);
    lin.header(RESP_FRAME_ID);
    lin.collect(40);
    check(lin.nGot, 0);
    // Responder disabled: a clean request must not go pending
    axiWrite(CTRL_ADDR, 32'h0, r);
    lin.request(nodeAddress, 1'b0);
    axiRead(CTRL_ADDR, d, r);
    check(d, 32'h0);
    axiWrite(CTRL_ADDR, 32'h1, r);
    $display("test refusals done");
    for (int it = 0; it < 6; it++) begin
      randomState(it);
      pulses();
      lin.request(nodeAddress, 1'b0);
      axiRead(CTRL_ADDR, d, r);
      check(d, 32'h9);
      lin.header(RESP_FRAME_ID);
      lin.collect(300);
      check(lin.nGot, 9);
      for (int i = 0; i < 8; i++) check({24'h0, lin.got[i]}, {24'h0, expByte(i)});
      check({24'h0, lin.got[8]}, {24'h0, lin.csum(lin.got)});
      axiRead(IRQ_STATUS_ADDR, d, r);
      check(d, {28'h0, bitE, 3'h3});
      axiWrite(IRQ_STATUS_ADDR, 32'hF, r);
      axiRead(FLAGS_ADDR, d, r);
      check(d, {16'h0, ledFaultLive, 3'h0, faultRetryEvent, supplyResetEvent, thermalShutdown,
                thermalWarning});
      {pSr, pTw, pTsd, pRt, pLed, linE, bitE} = {supplyResetEvent, thermalWarning, thermalShutdown,
                                                 faultRetryEvent, ledFaultLive, 4'h0};
      $display("test frame %0d done", it);
    end
    stopTest();
  end
endmodule
`default_nettype wire
